// *** dv/epil_pin_src.sv ***
// pin-side interrupt source model for the external pin latch
// assumes the bench says when the source pulls the pin low
`timescale 1ns/1ps
`default_nettype none
module epil_pin_src (
   input  wire logic core_clk,
   input  wire logic pull_low,
   input  wire logic pullup_enable,
   output logic      irq_pin_b
);
   logic tog_q = 1'b0;
   // an unpulled released pin floats, so show a level that keeps changing
   always @(posedge core_clk) tog_q <= ~tog_q;
   // released pin rises only through the enabled pull-up
   assign irq_pin_b = pull_low ? 1'b0 : (pullup_enable ? 1'b1 : tog_q);
endmodule
`default_nettype wire

// *** dv/test_external_pin_interrupt_latch.sv ***
// bench for the external pin interrupt latch, one task per scenario
// assumes pin sync takes three edges and reads answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module test_external_pin_interrupt_latch;
   import epil_pkg::*;
   localparam logic [7:0] SC = REG_STATUS_CONTROL;
   logic core_clk = 0, rst_b = 0, pull_low = 0, fetch_ack = 0, brk = 0;
   logic pin_b, pu_en, b_hi, b_lo;
   logic [7:0] rd_data;
   epil_bus_req_t req = '0;
   epil_cpu_req_t cpu_req;
   int fail_count = 0, cmp_count = 0;
   // free-running 40 MHz clock
   always #12.5 core_clk = ~core_clk;
   epil_pin_src src_u (.core_clk(core_clk), .pull_low(pull_low), .pullup_enable(pu_en),
      .irq_pin_b(pin_b));
   epil_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .irq_pin_b(pin_b),
      .vector_fetch_ack(fetch_ack), .break_state(brk), .bus_req(req), .rd_data(rd_data),
      .cpu_req(cpu_req), .pullup_enable(pu_en), .branch_if_pin_high(b_hi),
      .branch_if_pin_low(b_lo));
   task wrap_up;
      if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk) req <= '0;
   endtask
   // read data are valid only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk) req <= '0;
      #1 chk({8'h00, rd_data}, {8'h00, exp});
   endtask
   // move the pin, then let the synchroniser settle
   task pin(input logic low);
      @(posedge core_clk) pull_low <= low;
      repeat (4) @(posedge core_clk);
   endtask
   task t_reset;
      rd(SC, 8'h00);
      rd(REG_BREAK_CONTROL, 8'h00);
      chk(pu_en, 1);
   endtask
   task t_edge;
      pin(1);
      #1 chk(cpu_req.request, 1);
      chk(cpu_req.vec_high, 16'hFFFA);
      chk(cpu_req.vec_low, 16'hFFFB);
      chk({b_lo, b_hi}, 2'h2);
      wr(SC, 8'h02);
      #1 chk(cpu_req.request, 0);
      rd(SC, 8'h0A);
      wr(SC, 8'h06);
      rd(SC, 8'h02);
      rd(SC, 8'h02);
      pin(0);
      pin(1);
      rd(SC, 8'h0A);
      @(posedge core_clk) fetch_ack <= 1;
      @(posedge core_clk) fetch_ack <= 0;
      rd(SC, 8'h02);
      pin(0);
   endtask
   task t_level;
      wr(SC, 8'h01);
      pin(1);
      wr(SC, 8'h07);
      rd(SC, 8'h0B);
      pin(0);
      rd(SC, 8'h03);
      wr(SC, 8'h05);
      rd(SC, 8'h01);
      pin(1);
      @(posedge core_clk) rst_b <= 0;
      #1 chk(cpu_req.request, 0);
      @(posedge core_clk) rst_b <= 1;
      pin(0);
      wr(SC, 8'h04);
      rd(SC, 8'h00);
   endtask
   task t_break;
      pin(1);
      pin(0);
      @(posedge core_clk) brk <= 1;
      wr(SC, 8'h04);
      rd(SC, 8'h08);
      wr(REG_BREAK_CONTROL, 8'h80);
      wr(SC, 8'h04);
      @(posedge core_clk) brk <= 0;
      rd(SC, 8'h00);
      rd(8'h55, 8'h00);
      wr(REG_SECOND_CONFIG, 8'h01);
      #1 chk(pu_en, 0);
   endtask
   // main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge core_clk);
      rst_b <= 1;
      t_reset;
      t_edge;
      t_level;
      t_break;
      wrap_up;
   end
   // hang guard
   initial begin
      #100us fail_count++;
      wrap_up;
   end
endmodule
`default_nettype wire

// *** hdl/epil_pkg.sv ***
// constants and carrier types for the external pin interrupt latch
// assumes one bus clock domain and an 8-bit plain register port
package epil_pkg;
   localparam logic [7:0]  REG_STATUS_CONTROL = 8'h00; // status and control register
   localparam logic [7:0]  REG_SECOND_CONFIG  = 8'h1E; // second configuration register
   localparam logic [7:0]  REG_BREAK_CONTROL  = 8'h01; // break flag control register
   localparam int          BIT_MODE           = 0;
   localparam int          BIT_MASK           = 1;
   localparam int          BIT_ACK            = 2;
   localparam int          BIT_PENDING        = 3;
   localparam int          BIT_PULLUP_DIS     = 0;
   localparam int          BIT_BREAK_CLEAR    = 7;
   localparam logic [15:0] VECTOR_HIGH_ADDR   = 16'hFFFA;
   localparam logic [15:0] VECTOR_LOW_ADDR    = 16'hFFFB;
   localparam logic [7:0]  ZERO_BYTE          = 8'h00;
   localparam logic [1:0]  SYNC_FILL_DONE     = 2'h3; // edges until every pin stage holds a real sample

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } epil_bus_req_t;

   typedef struct packed {
      logic request;
      logic [15:0] vec_high;
      logic [15:0] vec_low;
   } epil_cpu_req_t;
endpackage

// *** hdl/epil_top.sv ***
// external pin interrupt latch: pin sampling, request latch, control register
// assumes the pin is synchronous-safe after two flops and the break state comes from the cpu side
//
// What this block does
// - falling pin edge, or in level mode a low pin sample, sets request latch
// - vector fetch, software acknowledge, reset clear latch
// - level mode clears need acknowledge plus pin high
// - level mode stays pending while pin low
// - reset clears latch and mode bit
// - edge mode: acknowledge clears latch immediately
// - edge after acknowledge latches new request
// - unmasked request points cpu at fixed vectors
// - pending flag ignores module mask
// - pending flag read-only, one when pending
// - acknowledge write-only, reads zero, clears latch
// - module mask read/write, one disables requests
// - mode bit read/write, reset clears
// - pull-up on unless disable bit set
// - break-clear enable lets acknowledge clear in break
// - break-clear disabled blocks acknowledge in break
// - pin level offered to branch instructions
// - request reaches priority logic only unmasked
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module epil_top (
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire logic                   irq_pin_b,
   input  wire logic                   vector_fetch_ack,
   input  wire logic                   break_state,
   input  wire epil_pkg::epil_bus_req_t bus_req,
   output logic [7:0]                  rd_data,
   output epil_pkg::epil_cpu_req_t     cpu_req,
   output logic                        pullup_enable,
   output logic                        branch_if_pin_high,
   output logic                        branch_if_pin_low
);
   import epil_pkg::*;

   logic sync1_q, sync2_q, prev_q;
   logic sync1_d, sync2_d, prev_d;
   logic latch_q, latch_d;
   logic mode_q, mode_d;
   logic mask_q, mask_d;
   logic pullup_dis_q, pullup_dis_d;
   logic break_clear_enable_q, break_clear_enable_d;
   logic [7:0] rd_data_q, rd_data_d;
   logic fall_edge, ack_write, sw_clear, clear_req, set_req;
   // an acknowledge taken in level mode while the pin is still low is remembered
   // here, so the pin's later return high can finish the clear in either order
   logic ack_pend_q, ack_pend_d;
   // the synchroniser stages reset to the idle level; until they hold real samples
   // a pin held low through reset would look like a fresh falling edge
   logic [1:0] fill_q, fill_d;
   logic armed;

   function automatic logic hit(input epil_bus_req_t r, input logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   // two-flop synchroniser; only sync2 and prev feed the edge detector
   always_comb begin
      sync1_d = irq_pin_b;
      sync2_d = sync1_q;
      prev_d  = sync2_q;
      fill_d  = armed ? fill_q : 2'(fill_q + 2'h1);
   end

   // no edge is believed until the pipeline is full of pin samples
   assign armed     = (fill_q == SYNC_FILL_DONE);
   assign fall_edge = armed && prev_q && !sync2_q;
   assign ack_write = hit(bus_req, REG_STATUS_CONTROL) && bus_req.wdata[BIT_ACK];
   // break protects the latch unless break-clear is enabled
   assign sw_clear  = ack_write && (!break_state || break_clear_enable_q);
   assign clear_req = vector_fetch_ack || sw_clear;
   // level mode keeps setting while low, so a clear only sticks once the pin is high
   assign set_req   = fall_edge || (mode_q && !sync2_q);

   // request latch and control bits; a new edge wins over a same-cycle clear
   always_comb begin
      latch_d              = latch_q;
      mode_d               = mode_q;
      mask_d               = mask_q;
      pullup_dis_d         = pullup_dis_q;
      break_clear_enable_d = break_clear_enable_q;
      if (clear_req || (ack_pend_q && sync2_q)) begin
         latch_d = 1'b0;
      end
      if (set_req) begin
         latch_d = 1'b1;
      end
      // in level mode a clear lost to a low pin waits for the pin to rise
      ack_pend_d = mode_q && latch_d && (ack_pend_q || clear_req);
      if (hit(bus_req, REG_STATUS_CONTROL)) begin
         mode_d = bus_req.wdata[BIT_MODE];
         mask_d = bus_req.wdata[BIT_MASK];
      end
      if (hit(bus_req, REG_SECOND_CONFIG)) begin
         pullup_dis_d = bus_req.wdata[BIT_PULLUP_DIS];
      end
      if (hit(bus_req, REG_BREAK_CONTROL)) begin
         break_clear_enable_d = bus_req.wdata[BIT_BREAK_CLEAR];
      end
   end

   // read mux; ack reads zero, unmapped addresses read zero
   always_comb begin
      rd_data_d = ZERO_BYTE;
      if (bus_req.rd) begin
         case (bus_req.addr)
            REG_STATUS_CONTROL: begin
               rd_data_d[BIT_PENDING] = latch_q;
               rd_data_d[BIT_MASK]    = mask_q;
               rd_data_d[BIT_MODE]    = mode_q;
            end
            REG_SECOND_CONFIG: rd_data_d[BIT_PULLUP_DIS] = pullup_dis_q;
            REG_BREAK_CONTROL: rd_data_d[BIT_BREAK_CLEAR] = break_clear_enable_q;
            default: rd_data_d = ZERO_BYTE;
         endcase
      end
   end

   // all state is reset; the pin stages load the idle high level, everything else clears
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q              <= 1'b1;
         sync2_q              <= 1'b1;
         prev_q               <= 1'b1;
         latch_q              <= 1'b0;
         mode_q               <= 1'b0;
         mask_q               <= 1'b0;
         pullup_dis_q         <= 1'b0;
         break_clear_enable_q <= 1'b0;
         rd_data_q            <= ZERO_BYTE;
         ack_pend_q           <= 1'b0;
         fill_q               <= 2'h0;
      end else begin
         sync1_q              <= sync1_d;
         sync2_q              <= sync2_d;
         prev_q               <= prev_d;
         latch_q              <= latch_d;
         mode_q               <= mode_d;
         mask_q               <= mask_d;
         pullup_dis_q         <= pullup_dis_d;
         break_clear_enable_q <= break_clear_enable_d;
         rd_data_q            <= rd_data_d;
         ack_pend_q           <= ack_pend_d;
         fill_q               <= fill_d;
      end
   end

   assign rd_data            = rd_data_q;
   assign cpu_req.request    = latch_q && !mask_q;
   assign cpu_req.vec_high   = VECTOR_HIGH_ADDR;
   assign cpu_req.vec_low    = VECTOR_LOW_ADDR;
   assign pullup_enable      = !pullup_dis_q;
   assign branch_if_pin_high = sync2_q;
   assign branch_if_pin_low  = !sync2_q;

   property p_edge_sets;
      @(posedge core_clk) disable iff (!rst_b) fall_edge |=> latch_q;
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("edge did not set latch");

   property p_vf_clears;
      @(posedge core_clk) disable iff (!rst_b)
         (vector_fetch_ack && !set_req) |=> !latch_q;
   endproperty
   a_vf_clears: assert property (p_vf_clears) else $error("fetch did not clear");

   property p_level_hold;
      @(posedge core_clk) disable iff (!rst_b) (mode_q && !sync2_q) |=> latch_q;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level lost");

   property p_edge_mode_clear;
      @(posedge core_clk) disable iff (!rst_b)
         (!mode_q && sw_clear && !fall_edge) |=> !latch_q;
   endproperty
   a_edge_mode_clear: assert property (p_edge_mode_clear) else $error("ack no clear");

   property p_break_protect;
      @(posedge core_clk) disable iff (!rst_b)
         (break_state && !break_clear_enable_q && !vector_fetch_ack && !ack_pend_q && latch_q)
            |=> latch_q;
   endproperty
   a_break_protect: assert property (p_break_protect) else $error("break clear");

   property p_mask_gate;
      @(posedge core_clk) disable iff (!rst_b) cpu_req.request == (latch_q && !mask_q);
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("mask gate wrong");

   property p_pending_read;
      @(posedge core_clk) disable iff (!rst_b)
         (bus_req.rd && bus_req.addr == REG_STATUS_CONTROL) |=>
            (rd_data[BIT_PENDING] == $past(latch_q) && !rd_data[BIT_ACK]);
   endproperty
   a_pending_read: assert property (p_pending_read) else $error("pending read bad");

   property p_sync_edge;
      @(posedge core_clk) disable iff (!rst_b)
         (armed && $fell(sync2_q) && $past(prev_q)) |-> fall_edge;
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("edge missed");

   // the checks below cover the clear paths, the register bits and the pin view;
   // each names the one event it watches, so a set in the same cycle is left out
   // wherever the set-wins choice would otherwise make the rule look broken

   property p_ack_order;
      @(posedge core_clk) disable iff (!rst_b)
         (ack_pend_q && sync2_q && !set_req) |=> !latch_q;
   endproperty
   a_ack_order: assert property (p_ack_order) else $error("late pin rise kept latch");

   property p_break_clear;
      @(posedge core_clk) disable iff (!rst_b)
         (ack_write && break_state && break_clear_enable_q && !set_req) |=> !latch_q;
   endproperty
   a_break_clear: assert property (p_break_clear) else $error("break clear ignored");

   property p_ack_then_edge;
      @(posedge core_clk) disable iff (!rst_b)
         (ack_write && fall_edge) |=> latch_q;
   endproperty
   a_ack_then_edge: assert property (p_ack_then_edge) else $error("edge lost to ack");

   property p_vector_fixed;
      @(posedge core_clk) disable iff (!rst_b)
         cpu_req.request |->
            (cpu_req.vec_high == VECTOR_HIGH_ADDR && cpu_req.vec_low == VECTOR_LOW_ADDR);
   endproperty
   a_vector_fixed: assert property (p_vector_fixed) else $error("vector moved");

   property p_masked_pending;
      @(posedge core_clk) disable iff (!rst_b)
         (bus_req.rd && bus_req.addr == REG_STATUS_CONTROL && mask_q) |=>
            (rd_data[BIT_PENDING] == $past(latch_q));
   endproperty
   a_masked_pending: assert property (p_masked_pending) else $error("mask hid flag");

   property p_rd_idle;
      @(posedge core_clk) disable iff (!rst_b)
         !bus_req.rd |=> (rd_data == ZERO_BYTE);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

   property p_ack_write_clear;
      @(posedge core_clk) disable iff (!rst_b)
         (ack_write && !break_state && !set_req) |=> !latch_q;
   endproperty
   a_ack_write_clear: assert property (p_ack_write_clear) else $error("ack ignored");

   property p_mask_write;
      @(posedge core_clk) disable iff (!rst_b)
         (bus_req.wr && bus_req.addr == REG_STATUS_CONTROL) |=>
            (mask_q == $past(bus_req.wdata[BIT_MASK]));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask not written");

   property p_mode_write;
      @(posedge core_clk) disable iff (!rst_b)
         (bus_req.wr && bus_req.addr == REG_STATUS_CONTROL) |=>
            (mode_q == $past(bus_req.wdata[BIT_MODE]));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode not written");

   property p_pullup_write;
      @(posedge core_clk) disable iff (!rst_b)
         (bus_req.wr && bus_req.addr == REG_SECOND_CONFIG) |=>
            (pullup_enable == !$past(bus_req.wdata[BIT_PULLUP_DIS]));
   endproperty
   a_pullup_write: assert property (p_pullup_write) else $error("pull-up wrong");

   property p_pin_level;
      @(posedge core_clk) disable iff (!rst_b)
         (branch_if_pin_high == $past(sync1_q)) && (branch_if_pin_low == !branch_if_pin_high);
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("pin level view wrong");

   property p_fill_quiet;
      @(posedge core_clk) disable iff (!rst_b)
         (!armed && !mode_q && !latch_q) |=> !latch_q;
   endproperty
   a_fill_quiet: assert property (p_fill_quiet) else $error("false edge after reset");

   property p_edge_vf_clear;
      @(posedge core_clk) disable iff (!rst_b)
         (!mode_q && vector_fetch_ack && !fall_edge) |=> !latch_q;
   endproperty
   a_edge_vf_clear: assert property (p_edge_vf_clear) else $error("fetch kept latch");
endmodule
`default_nettype wire
